// >>> verilog/cstp_top.sv
// How it works
// - bit order 0 sends LSB first, 1 MSB
// - codes 000-110 drive serial clock; in slow mode only 110 generates it
// - code 111 takes serial clock from pin
// - gear clock divided 512..2; slow: low clock/8
// - edge 0: shift on falling, sample rising
// - edge choice applies to both clock sources
// - mode 01 selects eight-bit transmit
// - config fields locked while transfer active
// - start without buffered byte sends undefined data
// - run sets active, shift flags, one irq
// - shift flag clears at eighth bit output
// - write with empty shifter loads it directly
// - write with full shifter sets buffer full
// - internal clock, empty buffer: idle, data high, wait
// - write after wait restarts shifting with irq
// - external clock, empty buffer: underrun flag set
// - status read clears underrun flag
// - buffer full at byte end: reload, irq
// - mode 00 forces stop, clears all flags
// - mode writes 01-11 ignored while running
// - run clear: finish byte or stop now, irq
`timescale 1ns/100ps

module cstp_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        low_speed_mode,
    input  wire logic        low_freq_tick,
    input  wire logic        serial_clock_pin_in,
    output logic             serial_clock_pin_out,
    output logic             serial_clock_pin_oe_n,
    output logic             serial_data_out_pin,
    output logic             serial_irq_request
);

    cstp_pkg::cstp_ctrl_t serial_control_reg;
    cstp_pkg::cstp_ctrl_t ctrl_wdata;
    logic [7:0]           tx_data_buffer_reg;
    logic [7:0]           shift_reg;
    logic [3:0]           bit_cnt_reg;
    logic                 transfer_active_flag_reg;
    logic                 shift_active_flag_reg;
    logic                 buffer_full_flag_reg;
    logic                 tx_underrun_flag_reg;
    logic                 shift_loaded_reg;
    logic                 phase_reg;
    logic [8:0]           div_cnt_reg;
    logic                 sclk_sync1_reg;
    logic                 sclk_sync2_reg;
    logic                 sclk_sync3_reg;
    logic [31:0]          prdata_reg;
    logic                 pready_reg;
    logic                 pslverr_reg;
    logic                 sclk_out_reg;
    logic                 sclk_oe_n_reg;
    logic                 sdo_reg;
    logic                 irq_reg;

    logic                 setup_phase;
    logic                 access_edge;
    logic                 ctrl_wr;
    logic                 buf_wr;
    logic                 stat_rd;
    logic                 ext_clk;
    logic                 clk_allowed;
    logic                 div_run;
    logic [8:0]           half_period;
    logic                 int_tick;
    logic                 ext_rise;
    logic                 ext_fall;
    logic                 tx_edge;
    logic                 rx_edge;
    logic                 next_bit;
    logic                 next_avail;
    logic [7:0]           next_byte;
    cstp_pkg::cstp_stat_t stat_view;

    // ---------------- bus decode ----------------
    assign setup_phase = psel & ~penable;
    assign access_edge = psel & penable & pready_reg;
    assign ctrl_wr     = access_edge & pwrite & (paddr == cstp_pkg::CSTP_CTRL_OFS);
    assign buf_wr      = access_edge & pwrite & (paddr == cstp_pkg::CSTP_BUF_OFS);
    assign stat_rd     = access_edge & ~pwrite & (paddr == cstp_pkg::CSTP_STAT_OFS);
    assign ctrl_wdata  = cstp_pkg::cstp_ctrl_t'(pwdata[7:0]);

    assign stat_view = '{active:     transfer_active_flag_reg,
                         shift:      shift_active_flag_reg,
                         rx_overrun: 1'b0,
                         rx_done:    1'b0,
                         underrun:   tx_underrun_flag_reg,
                         buf_full:   buffer_full_flag_reg,
                         zero:       2'h0};

    // no wait state: answer is registered during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= (paddr != cstp_pkg::CSTP_CTRL_OFS) && (paddr != cstp_pkg::CSTP_BUF_OFS)
                           && (paddr != cstp_pkg::CSTP_STAT_OFS);
            case (paddr)
                cstp_pkg::CSTP_CTRL_OFS: prdata_reg <= {24'h000000, serial_control_reg};
                cstp_pkg::CSTP_BUF_OFS:  prdata_reg <= {24'h000000, tx_data_buffer_reg};
                cstp_pkg::CSTP_STAT_OFS: prdata_reg <= {24'h000000, stat_view};
                default:                 prdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // ---------------- serial clock source ----------------
    assign ext_clk     = (serial_control_reg.clk_sel == cstp_pkg::CSTP_CKS_EXT);
    // in slow modes only the divide-by-8 code runs; any other internal code stalls the port
    assign clk_allowed = ~low_speed_mode | (serial_control_reg.clk_sel == cstp_pkg::CSTP_CKS_SLOW);
    assign half_period = low_speed_mode ? cstp_pkg::CSTP_SLOW_HALF
                                        : cstp_pkg::cstp_half_period(serial_control_reg.clk_sel);
    assign div_run     = transfer_active_flag_reg & shift_loaded_reg & ~ext_clk & clk_allowed;
    assign int_tick    = div_run & (div_cnt_reg == half_period - 9'h001)
                         & (~low_speed_mode | low_freq_tick);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 9'h000;
        end else if (!div_run || int_tick) begin
            div_cnt_reg <= 9'h000;
        end else if (!low_speed_mode || low_freq_tick) begin
            div_cnt_reg <= div_cnt_reg + 9'h001;
        end
    end

    // external clock: two-stage synchroniser, third stage only for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync1_reg <= 1'b1;
            sclk_sync2_reg <= 1'b1;
            sclk_sync3_reg <= 1'b1;
        end else begin
            sclk_sync1_reg <= serial_clock_pin_in;
            sclk_sync2_reg <= sclk_sync1_reg;
            sclk_sync3_reg <= sclk_sync2_reg;
        end
    end

    assign ext_rise = ext_clk & sclk_sync2_reg & ~sclk_sync3_reg;
    assign ext_fall = ext_clk & ~sclk_sync2_reg & sclk_sync3_reg;

    // internal clock: first tick of each bit is the transmit edge, second the sample edge
    assign tx_edge = ext_clk ? (serial_control_reg.edge_sel ? ext_rise : ext_fall)
                             : (int_tick & ~phase_reg);
    assign rx_edge = ext_clk ? (serial_control_reg.edge_sel ? ext_fall : ext_rise)
                             : (int_tick & phase_reg);

    assign next_bit   = serial_control_reg.bit_order ? shift_reg[7] : shift_reg[0];
    assign next_avail = buffer_full_flag_reg | buf_wr;
    assign next_byte  = buf_wr ? pwdata[7:0] : tx_data_buffer_reg;

    // ---------------- transfer engine and register file ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_reg       <= cstp_pkg::cstp_ctrl_t'(cstp_pkg::CSTP_CTRL_RST);
            tx_data_buffer_reg       <= cstp_pkg::CSTP_BUF_RST;
            shift_reg                <= 8'h00;
            bit_cnt_reg              <= 4'h0;
            transfer_active_flag_reg <= 1'b0;
            shift_active_flag_reg    <= 1'b0;
            buffer_full_flag_reg     <= 1'b0;
            tx_underrun_flag_reg     <= 1'b0;
            shift_loaded_reg         <= 1'b0;
            phase_reg                <= 1'b0;
            sclk_out_reg             <= 1'b1;
            sclk_oe_n_reg            <= 1'b1;
            sdo_reg                  <= 1'b1;
            irq_reg                  <= 1'b0;
        end else begin
            irq_reg       <= 1'b0;
            sclk_oe_n_reg <= ext_clk | (serial_control_reg.mode == cstp_pkg::CSTP_MODE_STOP);
            if (!transfer_active_flag_reg) begin
                sclk_out_reg <= ~serial_control_reg.edge_sel;
                phase_reg    <= 1'b0;
            end
            if (stat_rd) begin
                tx_underrun_flag_reg <= 1'b0;
            end
            if (ctrl_wr && ctrl_wdata.mode == cstp_pkg::CSTP_MODE_STOP) begin
                // forced stop wins over everything else in the same cycle
                serial_control_reg.mode  <= cstp_pkg::CSTP_MODE_STOP;
                serial_control_reg.run   <= 1'b0;
                transfer_active_flag_reg <= 1'b0;
                shift_active_flag_reg    <= 1'b0;
                buffer_full_flag_reg     <= 1'b0;
                tx_underrun_flag_reg     <= 1'b0;
                shift_loaded_reg         <= 1'b0;
                bit_cnt_reg              <= 4'h0;
                phase_reg                <= 1'b0;
                sdo_reg                  <= 1'b1;
                sclk_out_reg             <= ~serial_control_reg.edge_sel;
                // release the clock pin at once rather than a cycle after the stop
                sclk_oe_n_reg            <= 1'b1;
                if (!transfer_active_flag_reg) begin
                    serial_control_reg.edge_sel  <= ctrl_wdata.edge_sel;
                    serial_control_reg.clk_sel   <= ctrl_wdata.clk_sel;
                    serial_control_reg.bit_order <= ctrl_wdata.bit_order;
                    sclk_out_reg                 <= ~ctrl_wdata.edge_sel;
                end
            end else begin
                if (ctrl_wr && !transfer_active_flag_reg) begin
                    serial_control_reg.mode      <= ctrl_wdata.mode;
                    serial_control_reg.edge_sel  <= ctrl_wdata.edge_sel;
                    serial_control_reg.clk_sel   <= ctrl_wdata.clk_sel;
                    serial_control_reg.bit_order <= ctrl_wdata.bit_order;
                    serial_control_reg.run       <= ctrl_wdata.run & (ctrl_wdata.mode == cstp_pkg::CSTP_MODE_TX);
                    if (ctrl_wdata.run && ctrl_wdata.mode == cstp_pkg::CSTP_MODE_TX) begin
                        // an empty buffer here just sends whatever it holds
                        transfer_active_flag_reg <= 1'b1;
                        shift_active_flag_reg    <= 1'b1;
                        irq_reg                  <= 1'b1;
                        shift_reg                <= tx_data_buffer_reg;
                        shift_loaded_reg         <= 1'b1;
                        buffer_full_flag_reg     <= 1'b0;
                        bit_cnt_reg              <= 4'h0;
                        phase_reg                <= 1'b0;
                        sclk_out_reg             <= ~ctrl_wdata.edge_sel;
                    end
                end else if (ctrl_wr && !ctrl_wdata.run && serial_control_reg.run) begin
                    // only the run bit is taken while active; fields and mode are locked
                    serial_control_reg.run <= 1'b0;
                    if (!shift_active_flag_reg) begin
                        transfer_active_flag_reg <= 1'b0;
                        buffer_full_flag_reg     <= 1'b0;
                        shift_loaded_reg         <= 1'b0;
                        irq_reg                  <= 1'b1;
                        if (!ext_clk) begin
                            sdo_reg <= 1'b1;
                        end
                    end
                end

                if (buf_wr) begin
                    tx_data_buffer_reg <= pwdata[7:0];
                    if (transfer_active_flag_reg && !shift_loaded_reg) begin
                        shift_reg             <= pwdata[7:0];
                        shift_loaded_reg      <= 1'b1;
                        shift_active_flag_reg <= 1'b1;
                        bit_cnt_reg           <= 4'h0;
                        buffer_full_flag_reg  <= 1'b0;
                        irq_reg               <= ~ext_clk;
                    end else if (transfer_active_flag_reg) begin
                        buffer_full_flag_reg <= 1'b1;
                    end
                end

                if (transfer_active_flag_reg && tx_edge) begin
                    if (!ext_clk) begin
                        sclk_out_reg <= serial_control_reg.edge_sel;
                        phase_reg    <= 1'b1;
                    end
                    if (shift_loaded_reg && bit_cnt_reg != cstp_pkg::CSTP_BITS) begin
                        sdo_reg     <= next_bit;
                        shift_reg   <= serial_control_reg.bit_order ? {shift_reg[6:0], 1'b0}
                                                                    : {1'b0, shift_reg[7:1]};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == cstp_pkg::CSTP_BITS - 4'h1) begin
                            shift_active_flag_reg <= 1'b0;
                        end
                    end else if (!shift_loaded_reg) begin
                        // clocked past the end of data: line keeps its last value
                        tx_underrun_flag_reg <= 1'b1;
                    end
                end

                if (transfer_active_flag_reg && rx_edge) begin
                    if (!ext_clk) begin
                        sclk_out_reg <= ~serial_control_reg.edge_sel;
                        phase_reg    <= 1'b0;
                    end
                    if (shift_loaded_reg && bit_cnt_reg == cstp_pkg::CSTP_BITS) begin
                        bit_cnt_reg <= 4'h0;
                        if (!serial_control_reg.run) begin
                            transfer_active_flag_reg <= 1'b0;
                            shift_active_flag_reg    <= 1'b0;
                            buffer_full_flag_reg     <= 1'b0;
                            shift_loaded_reg         <= 1'b0;
                            irq_reg                  <= 1'b1;
                            if (!ext_clk) begin
                                sdo_reg <= 1'b1;
                            end
                        end else if (next_avail) begin
                            shift_reg             <= next_byte;
                            buffer_full_flag_reg  <= 1'b0;
                            shift_active_flag_reg <= 1'b1;
                            irq_reg               <= 1'b1;
                        end else begin
                            shift_loaded_reg <= 1'b0;
                            if (!ext_clk) begin
                                sdo_reg <= 1'b1;
                            end
                        end
                    end
                end
            end
        end
    end

    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
    assign serial_clock_pin_out  = sclk_out_reg;
    assign serial_clock_pin_oe_n = sclk_oe_n_reg;
    assign serial_data_out_pin   = sdo_reg;
    assign serial_irq_request    = irq_reg;

endmodule // cstp_top

// >>> verilog/cstp_pkg.sv
package cstp_pkg;

    // register byte offsets on the APB
    localparam logic [11:0] CSTP_CTRL_OFS   = 12'h000;
    localparam logic [11:0] CSTP_BUF_OFS    = 12'h004;
    localparam logic [11:0] CSTP_STAT_OFS   = 12'h008;

    // transfer mode field codes
    localparam logic [1:0]  CSTP_MODE_STOP  = 2'h0;
    localparam logic [1:0]  CSTP_MODE_TX    = 2'h1;

    // clock select codes
    localparam logic [2:0]  CSTP_CKS_SLOW   = 3'h6;
    localparam logic [2:0]  CSTP_CKS_EXT    = 3'h7;

    // bits in a byte, and low-frequency ticks per serial clock half period (divide by 8)
    localparam logic [3:0]  CSTP_BITS       = 4'h8;
    localparam logic [8:0]  CSTP_SLOW_HALF  = 9'h004;

    // reset values
    localparam logic [7:0]  CSTP_CTRL_RST   = 8'h00;
    localparam logic [7:0]  CSTP_BUF_RST    = 8'h00;
    localparam logic [7:0]  CSTP_STAT_RST   = 8'h00;

    // control register layout: mode [7:6], run 5, bit order 4, clock select [3:1], edge 0
    typedef struct packed {
        logic [1:0] mode;
        logic       run;
        logic       bit_order;
        logic [2:0] clk_sel;
        logic       edge_sel;
    } cstp_ctrl_t;

    // status register layout; receive flags and bits 1:0 always read zero here
    typedef struct packed {
        logic       active;
        logic       shift;
        logic       rx_overrun;
        logic       rx_done;
        logic       underrun;
        logic       buf_full;
        logic [1:0] zero;
    } cstp_stat_t;

    // gear clock cycles per serial clock half period for codes 000..110
    function automatic logic [8:0] cstp_half_period(input logic [2:0] cks);
        logic [8:0] h;
        h = 9'h001;
        case (cks)
            3'h0:    h = 9'h100;
            3'h1:    h = 9'h020;
            3'h2:    h = 9'h010;
            3'h3:    h = 9'h008;
            3'h4:    h = 9'h004;
            3'h5:    h = 9'h002;
            default: h = 9'h001;
        endcase
        return h;
    endfunction

endpackage

// >>> tb/cstp_properties.sv
`timescale 1ns/100ps
module cstp_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [7:0]  pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_clock_pin_out,
    input wire logic        serial_clock_pin_oe_n,
    input wire logic        serial_data_out_pin,
    input wire logic        serial_irq_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic setup;
    logic hit;
    logic stop_wr;
    assign setup = psel && !penable;
    assign hit = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
    assign stop_wr = psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[7:6] == 2'h0;
    answer_after_setup_a: assert property (setup |=> pready) else $error("no answer after setup");
    ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready held too long");
    unmapped_error_a: assert property (setup && !hit |=> pslverr) else $error("no error on unmapped");
    mapped_no_error_a: assert property (setup && hit |=> !pslverr) else $error("error on mapped");
    error_reads_zero_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("unmapped data");
    irq_one_pulse_a: assert property (serial_irq_request |=> !serial_irq_request) else $error("irq too long");
    stop_line_idle_a: assert property (stop_wr |=> (serial_data_out_pin && serial_clock_pin_oe_n) [*2])
        else $error("forced stop left lines active");
    data_on_edge_a: assert property (!serial_clock_pin_oe_n && !$past(serial_clock_pin_oe_n)
        && $changed(serial_data_out_pin) |-> $changed(serial_clock_pin_out) || serial_data_out_pin)
        else $error("data moved off a clock edge");
endmodule // cstp_properties

bind cstp_top cstp_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata(pwdata[7:0]),
    .prdata, .pready, .pslverr, .serial_clock_pin_out, .serial_clock_pin_oe_n, .serial_data_out_pin,
    .serial_irq_request);

// >>> tb/cstp_far_end.sv
`timescale 1ns/100ps
module cstp_far_end (
    input  wire logic       pclk,
    input  wire logic       sclk,
    input  wire logic       sdo,
    input  wire logic       edge_sel,
    input  wire logic       msb_first,
    input  wire logic       clr,
    output logic            ext_clk,
    output logic      [7:0] rx_byte,
    output int              rx_count
);
    logic       sclk_q = 1'b1;
    logic       sdo_q = 1'b1;
    logic       tgl = 1'b1;
    logic       running = 1'b0;
    logic [7:0] sh = 8'h00;
    int         bits = 0;
    initial rx_count = 0;
    // clock rests at the idle level between frames
    assign ext_clk = running ? tgl : ~edge_sel;
    task run_clock(input int n);
        @(posedge pclk);
        tgl <= ~edge_sel;
        running <= 1'b1;
        repeat (n) begin
            repeat (8) @(posedge pclk);
            tgl <= edge_sel;
            repeat (8) @(posedge pclk);
            tgl <= ~edge_sel;
        end
        repeat (8) @(posedge pclk);
        running <= 1'b0;
    endtask
    // data taken one cycle old: the line may change in the same edge as the clock
    always @(posedge pclk) begin
        sclk_q <= sclk;
        sdo_q <= sdo;
        if (clr)
            bits = 0;
        else if (sclk !== sclk_q && sclk === ~edge_sel) begin
            sh = msb_first ? {sh[6:0], sdo_q} : {sdo_q, sh[7:1]};
            bits++;
            if (bits == 8) begin
                rx_byte <= sh;
                rx_count <= rx_count + 1;
                bits = 0;
            end
        end
    end
endmodule // cstp_far_end

// >>> tb/cstp_top_bench.sv
`timescale 1ns/100ps
module cstp_top_bench;
    localparam logic [11:0] cr = cstp_pkg::CSTP_CTRL_OFS;
    localparam logic [11:0] br = cstp_pkg::CSTP_BUF_OFS;
    localparam logic [11:0] sr = cstp_pkg::CSTP_STAT_OFS;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, serial_clock_pin_out, serial_clock_pin_oe_n, serial_data_out_pin;
    logic        serial_irq_request, serial_clock_pin_in, ext_clk, err, v;
    logic        low_speed_mode = 1'b0, low_freq_tick = 1'b0, p_edge = 1'b0, p_msb = 1'b0, p_clr = 1'b1;
    logic [7:0]  rx_byte, rd;
    int          rx_count, base, irq0, irqs = 0, cyc = 0, miscompares = 0, check_count = 0;
    int          half_tbl[7] = '{256, 32, 16, 8, 4, 2, 1};
    always #10 pclk = ~pclk;
    assign serial_clock_pin_in = (serial_clock_pin_oe_n === 1'b0) ? serial_clock_pin_out : ext_clk;
    cstp_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .low_speed_mode, .low_freq_tick, .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe_n,
        .serial_data_out_pin, .serial_irq_request);
    cstp_far_end i_far (.pclk, .sclk(serial_clock_pin_in), .sdo(serial_data_out_pin), .edge_sel(p_edge),
        .msb_first(p_msb), .clr(p_clr), .ext_clk, .rx_byte, .rx_count);
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        low_freq_tick <= (cyc % 3 == 0);
        if (serial_irq_request === 1'b1)
            irqs <= irqs + 1;
        if (cyc == 30000) begin
            miscompares++;
            stop_test;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check("register", {24'h0, rd}, {24'h0, exp});
    endtask
    // the far end ignores the wire while the port is reconfigured
    task automatic prep(input logic o, input logic e, input logic s, input logic [7:0] d);
        p_clr <= 1'b1;
        apb(1'b1, cr, 8'h00);
        low_speed_mode <= s;
        p_msb <= o;
        p_edge <= e;
        apb(1'b1, br, d);
        p_clr <= 1'b0;
        base = rx_count;
        irq0 = irqs;
    endtask
    task automatic wait_rx(input int n, input logic [7:0] exp);
        while (rx_count < n) @(posedge pclk);
        check("byte", {24'h0, rx_byte}, {24'h0, exp});
    endtask
    task automatic t_regs;
        rd_chk(cr, 8'h00);
        rd_chk(sr, 8'h00);
        apb(1'b1, br, 8'h77);
        rd_chk(br, 8'h77);
        apb(1'b1, 12'h00C, 8'hFF);
        check("slverr", {31'h0, err}, 32'h1);
        rd_chk(12'h00C, 8'h00);
        check("slverr", {31'h0, err}, 32'h1);
    endtask
    task automatic t_tx(input logic o, input logic e, input logic [2:0] c, input logic s, input logic [7:0] d);
        int k;
        prep(o, e, s, d);
        apb(1'b1, cr, {2'b01, 1'b1, o, c, e});
        v = serial_clock_pin_out;
        while (serial_clock_pin_out === v) @(posedge pclk);
        v = serial_clock_pin_out;
        k = 0;
        while (serial_clock_pin_out === v) begin
            @(posedge pclk);
            k++;
        end
        check("half period", k, s ? 12 : half_tbl[c]);
        check("clock driven", {31'h0, serial_clock_pin_oe_n}, 32'h0);
        wait_rx(base + 1, d);
        repeat (4) @(posedge pclk);
        rd_chk(sr, 8'h80);
        check("idle lines", {serial_data_out_pin, serial_clock_pin_out}, {1'b1, ~e});
        check("irqs", irqs - irq0, 1);
        apb(1'b1, cr, 8'h00);
        rd_chk(sr, 8'h00);
    endtask
    task automatic t_buf;
        prep(1'b0, 1'b0, 1'b0, 8'h5A);
        apb(1'b1, cr, 8'h6A);
        apb(1'b1, cr, 8'hB9);
        rd_chk(cr, 8'h6A);
        apb(1'b1, br, 8'hC3);
        rd_chk(sr, 8'hC4);
        apb(1'b1, br, 8'h3C);
        wait_rx(base + 1, 8'h5A);
        wait_rx(base + 2, 8'h3C);
        repeat (4) @(posedge pclk);
        rd_chk(sr, 8'h80);
        apb(1'b1, br, 8'h96);
        rd_chk(sr, 8'hC0);
        apb(1'b1, cr, 8'h4A);
        wait_rx(base + 3, 8'h96);
        repeat (4) @(posedge pclk);
        rd_chk(sr, 8'h00);
        check("irqs", irqs - irq0, 4);
    endtask
    task automatic t_ext(input logic e, input logic [7:0] d);
        prep(1'b1, e, 1'b0, d);
        apb(1'b1, cr, {2'b01, 1'b1, 1'b1, cstp_pkg::CSTP_CKS_EXT, e});
        i_far.run_clock(8);
        check("clock input", {31'h0, serial_clock_pin_oe_n}, 32'h1);
        wait_rx(base + 1, d);
        rd_chk(sr, 8'h80);
        v = serial_data_out_pin;
        i_far.run_clock(2);
        check("held data", {31'h0, serial_data_out_pin}, {31'h0, v});
        rd_chk(sr, 8'h88);
        rd_chk(sr, 8'h80);
        irq0 = irqs;
        apb(1'b1, cr, {2'b01, 1'b0, 1'b1, cstp_pkg::CSTP_CKS_EXT, e});
        repeat (2) @(posedge pclk);
        rd_chk(sr, 8'h00);
        check("irqs", irqs - irq0, 1);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        for (int c = 0; c < 7; c++)
            t_tx(c[0], c[1], 3'(c), 1'b0, 8'(8'hA1 + c * 37));
        t_tx(1'b1, 1'b0, cstp_pkg::CSTP_CKS_SLOW, 1'b1, 8'h4D);
        t_buf;
        t_ext(1'b0, 8'hB2);
        t_ext(1'b1, 8'h1E);
        stop_test;
    end
endmodule // cstp_top_bench
